// file: pwc_pkg.sv
`default_nettype none
package pwc_pkg;
  // Bus and data widths
  localparam int CNT_W = 32;
  typedef logic [7:0]  pwc_addr_t;
  typedef logic [31:0] pwc_data_t;
  typedef logic [9:0]  pwc_pre_t;

  // Register byte offsets
  localparam pwc_addr_t OFF_CONFIG  = 8'h00;
  localparam pwc_addr_t OFF_COMMAND = 8'h04;
  localparam pwc_addr_t OFF_STATUS  = 8'h08;
  localparam pwc_addr_t OFF_MASK    = 8'h0c;
  localparam pwc_addr_t OFF_CAPTURE = 8'h10;
  localparam pwc_addr_t OFF_OVFCAP  = 8'h14;
  localparam pwc_addr_t OFF_INFO    = 8'h18;
  localparam pwc_addr_t OFF_COUNT   = 8'h1c;

  // Field positions in COMMAND, STATUS/MASK and INFO
  localparam int CMD_ENABLE_BIT  = 0;
  localparam int CMD_DISABLE_BIT = 1;
  localparam int ST_CAPTURE_BIT  = 0;
  localparam int ST_OVERFLOW_BIT = 1;
  localparam int INFO_ENABLE_BIT = 0;
  localparam int INFO_RUN_BIT    = 1;
  localparam int CFG_W           = 15;
  localparam int EVT_W           = 2;

  // Configuration word, low bits of CONFIG; msb first
  typedef struct packed {
    logic [2:0] en_flt;     // 14:12  0 none, 1..4 = pclk/1,/4,/16,/64
    logic [1:0] en_lvl;     // 11:10  see LVL_NONE, LVL_LOW, LVL_HIGH codes
    logic [2:0] clk_div;    // 9:7    0..5 = pclk/1,/4,/16,/64,/256,/1024
    logic [2:0] sig_flt;    // 6:4    as en_flt
    logic       sig_sel_b;  // 3      0 capture_pin_a, 1 capture_pin_b
    logic       auto_start; // 2
    logic       one_shot;   // 1
    logic       fall_start; // 0      0 rising start
  } pwc_cfg_s;

  localparam logic [CFG_W-1:0] CFG_RESET = 15'h0004;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [2:0] FLT_NONE = 3'h0;

  typedef enum logic {PWC_IDLE, PWC_MEAS} pwc_state_e;

  // Tick of a divide-by-4^k strobe from the shared free-running prescaler
  function automatic logic pwc_tick(input pwc_pre_t pre, input logic [2:0] k);
    logic t;
    t = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      if (i < 2 * int'(k))
        t = t & ~pre[i];
    end
    return t;
  endfunction
endpackage
`default_nettype wire

// file: pwc_top.sv
// Summary of operation
// - Only pulse width is measured: from a start edge to the next opposite edge.
// - Start edge rising by default or falling by configuration; stop on opposite edge.
// - One-shot takes one measurement then disables; periodic measures continuously.
// - Auto start enables measurement after configuring; otherwise wait for explicit enable.
// - Signal input is capture_pin_a by default, or capture_pin_b.
// - Signal filter samples at clock /1,/4,/16,/64; three equal samples pass a level.
// - Measurement counter runs at clock /1,/4,/16,/64,/256 or /1024, default /1.
// - The pin not used as signal may act as hardware enable gating captures.
// - Enable level none keeps captures enabled regardless of the enable pin.
// - Enable level low allows captures only while filtered enable input is low.
// - Enable level high allows captures only while filtered enable input is high.
// - Enable filter samples at clock /1,/4,/16,/64; three equal samples accept a level.
// - The channel is clocked by peripheral_clock_d ahead of the prescaler.
// - Completion reports captured count and overflows seen during that measurement.
// - Start needs the selected edge and the enable condition in the same moment.
//
// The plain strobed port and the register offsets were decided locally.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Pin conditioner: three-stage synchroniser then optional 3-sample filter
module pwc_filt (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Pin and settings
  input  wire logic             pin,
  input  wire logic [2:0]       mode,
  input  wire pwc_pkg::pwc_pre_t pre,
  // Conditioned level
  output logic                  lvl
);
  import pwc_pkg::*;

  logic       s1_q, s2_q, s3_q;
  logic       sync_q;
  logic [2:0] smp_q;
  logic       tick;

  // Synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        sync_q <= s3_q;
    end
  end

  // Mode 1..4 maps to divide 1,4,16,64
  assign tick = (mode != FLT_NONE) && pwc_tick(pre, mode - 3'h1);

  // Sample shift and level acceptance
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smp_q <= 3'h0;
      lvl   <= 1'b0;
    end
    else
    begin
      // With the filter off the samples track the pin, so switching it on
      // cannot bring back a level that was sampled long ago
      if (mode == FLT_NONE)
        smp_q <= {3{sync_q}};
      else if (tick)
        smp_q <= {smp_q[1:0], sync_q};
      if (mode == FLT_NONE)
        lvl <= sync_q;
      else if (smp_q == 3'h7 || smp_q == 3'h0)
        lvl <= smp_q[0];
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Pulse width capture channel
module pwc_top (
  // Clock and reset; clk is peripheral_clock_d
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Register port
  input  wire pwc_pkg::pwc_addr_t reg_addr,
  input  wire pwc_pkg::pwc_data_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output pwc_pkg::pwc_data_t      reg_rdata,
  // Channel pins
  input  wire logic               capture_pin_a,
  input  wire logic               capture_pin_b,
  // Interrupt
  output logic                    irq
);
  import pwc_pkg::*;

  pwc_cfg_s               cfg_q;
  pwc_state_e             state_q;
  pwc_pre_t               pre_q;
  logic                   ena_q;
  logic [EVT_W-1:0]       status_q, mask_q, evt;
  logic [CNT_W-1:0]       cnt_q, ovf_q, cap_q, ovfcap_q;
  logic                   lvl_a, lvl_b;
  logic                   sig_prev_q;
  logic                   sig, en_in, gate_ok, rise, fall;
  logic                   start_hit, stop_hit, cnt_tick, wrap;
  logic                   wr_cfg, wr_cmd;
  logic                   abort;
  logic [2:0]             settle_q;
  pwc_cfg_s               cfg_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler, free running on peripheral_clock_d
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pre_q <= '0;
    else
      pre_q <= pre_q + 10'h001;
  end

  // Each pin has its own conditioner; the signal filter follows the signal role
  pwc_filt u_filt_a (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (capture_pin_a),
    .mode  (cfg_q.sig_sel_b ? cfg_q.en_flt : cfg_q.sig_flt),
    .pre   (pre_q),
    .lvl   (lvl_a)
  );

  pwc_filt u_filt_b (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (capture_pin_b),
    .mode  (cfg_q.sig_sel_b ? cfg_q.sig_flt : cfg_q.en_flt),
    .pre   (pre_q),
    .lvl   (lvl_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Signal routing, gating and edge detection
  assign sig   = cfg_q.sig_sel_b ? lvl_b : lvl_a;
  assign en_in = cfg_q.sig_sel_b ? lvl_a : lvl_b;

  always_comb
  begin
    case (cfg_q.en_lvl)
      LVL_LOW:  gate_ok = ~en_in;
      LVL_HIGH: gate_ok = en_in;
      default:  gate_ok = 1'b1;
    endcase
  end

  assign rise = sig & ~sig_prev_q & (&settle_q);
  assign fall = ~sig & sig_prev_q & (&settle_q);

  // Start on the chosen edge, stop on the opposite one
  assign start_hit = (state_q == PWC_IDLE) && ena_q && gate_ok && !abort
                     && (cfg_q.fall_start ? fall : rise);
  assign stop_hit  = (state_q == PWC_MEAS) && (cfg_q.fall_start ? rise : fall);

  assign cnt_tick = pwc_tick(pre_q, cfg_q.clk_div);
  assign wrap     = (state_q == PWC_MEAS) && !stop_hit && cnt_tick && (&cnt_q);

  assign wr_cfg = reg_wr && (reg_addr == OFF_CONFIG);
  assign wr_cmd = reg_wr && (reg_addr == OFF_COMMAND);

  // Settings written this cycle, seen through the configuration layout
  assign cfg_wr = pwc_cfg_s'(reg_wdata[CFG_W-1:0]);

  // A settings write or a plain disable ends or refuses a measurement at the write
  // edge itself, so a following INFO read never shows a run software has stopped
  assign abort = wr_cfg || (wr_cmd && reg_wdata[CMD_DISABLE_BIT] && !reg_wdata[CMD_ENABLE_BIT]);

  // Previous conditioned signal level for edge detection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sig_prev_q <= 1'b0;
    else
      sig_prev_q <= sig;
  end

  // Edges are ignored until the pins have passed the synchronisers, so a pin
  // idling high shows no false rising edge after reset (filters are off then)
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settle_q <= '0;
    else if (!(&settle_q))
      settle_q <= settle_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_q <= pwc_cfg_s'(CFG_RESET);
    else if (wr_cfg)
      cfg_q <= cfg_wr;
  end

  // Capture enable; reset default counts as configured with auto start on
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ena_q <= 1'b1;
    else if (wr_cmd && reg_wdata[CMD_ENABLE_BIT])
      ena_q <= 1'b1;
    else if (wr_cmd && reg_wdata[CMD_DISABLE_BIT])
      ena_q <= 1'b0;
    else if (wr_cfg)
      ena_q <= cfg_wr.auto_start;
    else if (stop_hit && cfg_q.one_shot)
      ena_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement state; disabling aborts a measurement in flight
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= PWC_IDLE;
    else
    begin
      case (state_q)
        PWC_IDLE:
          if (start_hit)
            state_q <= PWC_MEAS;
        PWC_MEAS:
          if (stop_hit || !ena_q || abort)
            state_q <= PWC_IDLE;
        default:
          state_q <= PWC_IDLE;
      endcase
    end
  end

  // Counter and overflow count
  // The prescaler is shared and free running, so the first count tick of a
  // measurement may come up to one divided period early
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      ovf_q <= '0;
    end
    else if (start_hit)
    begin
      cnt_q <= '0;
      ovf_q <= '0;
    end
    else if (stop_hit && cfg_q.one_shot)
      cnt_q <= '0;
    else if (state_q == PWC_MEAS && !stop_hit && cnt_tick)
    begin
      cnt_q <= cnt_q + 32'h1;
      if (wrap)
        ovf_q <= ovf_q + 32'h1;
    end
  end

  // Captured result, held until the next completion
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cap_q    <= '0;
      ovfcap_q <= '0;
    end
    else if (stop_hit)
    begin
      cap_q    <= cnt_q;
      ovfcap_q <= ovf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a new event beats a same-cycle write-one clear
  assign evt = {wrap, stop_hit};

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      status_q <= '0;
    else if (reg_wr && reg_addr == OFF_STATUS)
      status_q <= (status_q & ~reg_wdata[EVT_W-1:0]) | evt;
    else
      status_q <= status_q | evt;
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mask_q <= '0;
    else if (reg_wr && reg_addr == OFF_MASK)
      mask_q <= reg_wdata[EVT_W-1:0];
  end

  // Registered so irq comes from a flop; it lags status and mask by one cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(status_q & mask_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe and zero otherwise
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else
    begin
      case (reg_addr)
        OFF_CONFIG:  reg_rdata <= {17'h0, cfg_q};
        OFF_STATUS:  reg_rdata <= {30'h0, status_q};
        OFF_MASK:    reg_rdata <= {30'h0, mask_q};
        OFF_CAPTURE: reg_rdata <= cap_q;
        OFF_OVFCAP:  reg_rdata <= ovfcap_q;
        OFF_INFO:    reg_rdata <= {30'h0, state_q == PWC_MEAS, ena_q};
        OFF_COUNT:   reg_rdata <= cnt_q;
        default:     reg_rdata <= '0; // Unmapped and COMMAND read zero
      endcase
    end
  end
endmodule
`default_nettype wire

// file: pwc_chk.sv
`default_nettype none
////////////////////////////////////////////////////////////
// Register port and interrupt checks on the capture channel
module pwc_chk (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_b,
  // Register port
  input wire pwc_pkg::pwc_addr_t reg_addr,
  input wire pwc_pkg::pwc_data_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire pwc_pkg::pwc_data_t reg_rdata,
  // Pins and interrupt
  input wire logic               capture_pin_a,
  input wire logic               capture_pin_b,
  input wire logic               irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Data stand one cycle only, so stale words never pass for a fresh read
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  a_cmd_zero:
    assert property (reg_rd && reg_addr == OFF_COMMAND |=> reg_rdata == 32'h0) else $error("command read");
  a_unmapped_zero:
    assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0) else $error("unmapped read");
  // Settings read back exactly as written
  a_cfg_readback:
    assert property (reg_wr && reg_addr == OFF_CONFIG ##1 reg_rd && reg_addr == OFF_CONFIG
      |=> reg_rdata == {17'h0, $past(reg_wdata[14:0], 2)}) else $error("config readback");
  // A settings write aborts and leaves enable equal to auto start
  a_auto_start:
    assert property (reg_wr && reg_addr == OFF_CONFIG ##1 reg_rd && reg_addr == OFF_INFO
      |=> reg_rdata[1:0] == {1'b0, $past(reg_wdata[2], 2)}) else $error("auto start");
  a_disable_info:
    assert property (reg_wr && reg_addr == OFF_COMMAND && reg_wdata[1:0] == 2'h2 ##1 reg_rd && reg_addr == OFF_INFO
      |=> reg_rdata[1:0] == 2'h0) else $error("disable");
  a_enable_info:
    assert property (reg_wr && reg_addr == OFF_COMMAND && reg_wdata[0] ##1 reg_rd && reg_addr == OFF_INFO
      |=> reg_rdata[0]) else $error("enable");
  // Irq lags the mask by one register stage
  a_mask_quiet:
    assert property (reg_wr && reg_addr == OFF_MASK && reg_wdata[1:0] == 2'h0 ##1 !reg_wr |=> !irq)
      else $error("masked irq");
endmodule
////////////////////////////////////////////////////////////
bind pwc_top pwc_chk chk_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin_a(capture_pin_a),
  .capture_pin_b(capture_pin_b), .irq(irq));
`default_nettype wire

// file: pwc_src.sv
`default_nettype none
////////////////////////////////////////////////////////////
// Pulse source with a hardware enable level on the other pin
module pwc_src (
  // Clock and pin choice
  input  wire logic clk,
  input  wire logic sel_b,
  // Channel pins
  output logic      capture_pin_a,
  output logic      capture_pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sig = 1'b0;
  logic en  = 1'b0;
  // Signal on the chosen pin, enable level on the other
  assign capture_pin_a = sel_b ? en : sig;
  assign capture_pin_b = sel_b ? sig : en;
  // Settle long enough for sync and filters before the pulse edges
  task automatic pulse(input int w, input logic idle, input logic lvl);
    sig <= idle;
    en  <= lvl;
    repeat (8) @(posedge clk);
    sig <= ~idle;
    repeat (w) @(posedge clk);
    sig <= idle;
    repeat (14) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: pulse_width_capture_bench.sv
`default_nettype none
////////////////////////////////////////////////////////////
// Self-checking bench for the capture channel
module pulse_width_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pwc_pkg::*;
  typedef struct packed {
    logic [14:0] cfg;
    logic [7:0]  w;
    logic [7:0]  e;
    logic        idle;
    logic        en;
  } pwc_row_s;
  logic      clk, rst_b, reg_wr, reg_rd, src_sel, irq, iv, ok, capture_pin_a, capture_pin_b;
  pwc_addr_t reg_addr;
  pwc_data_t reg_wdata, reg_rdata, rv;
  int        fail_count, checked;
  // Settings, pulse width, expected count, idle level, enable pin level
  pwc_row_s  rows [10] = '{
    '{15'h0004, 8'h14, 8'h14, 1'b0, 1'b0},
    '{15'h000c, 8'h10, 8'h10, 1'b0, 1'b0},
    '{15'h0084, 8'h28, 8'h0a, 1'b0, 1'b0},
    '{15'h0184, 8'h80, 8'h02, 1'b0, 1'b0},
    '{15'h0104, 8'ha0, 8'h0a, 1'b0, 1'b0},
    '{15'h0014, 8'h14, 8'h14, 1'b0, 1'b0},
    '{15'h0804, 8'h14, 8'h14, 1'b0, 1'b1},
    '{15'h0404, 8'h14, 8'h14, 1'b0, 1'b0},
    '{15'h1804, 8'h14, 8'h14, 1'b0, 1'b1},
    '{15'h0005, 8'h14, 8'h14, 1'b1, 1'b0}};
  // Clock at 125 MHz
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  pwc_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin_a(capture_pin_a), .capture_pin_b(capture_pin_b), .irq(irq));
  pwc_src src_u (.clk(clk), .sel_b(src_sel), .capture_pin_a(capture_pin_a), .capture_pin_b(capture_pin_b));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input pwc_data_t e, input pwc_data_t g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write strobe stays up until the next transfer lowers it, so no step drives it twice
  task automatic wr(input pwc_addr_t a, input pwc_data_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    @(posedge clk);
  endtask
  // Data and irq sampled mid-cycle, clear of the loading edge
  task automatic rd(input pwc_addr_t a);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
    iv = irq;
    @(posedge clk);
  endtask
  task automatic go(input int w, input logic idle, input logic en);
    reg_wr <= 1'b0;
    src_u.pulse(w, idle, en);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog, far beyond the thousand or so cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    {rst_b, reg_wr, reg_rd, src_sel, reg_addr, reg_wdata} = '0;
    fail_count = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFF_CONFIG);
    chk("config", {17'h0, CFG_RESET}, rv);
    chk("irq", 32'h0, {31'h0, iv});
    rd(OFF_INFO);
    chk("info", 32'h1, rv);
    // Ordinary measurements, one per row
    foreach (rows[i])
    begin
      src_sel <= rows[i].cfg[3];
      wr(OFF_CONFIG, {17'h0, rows[i].cfg});
      wr(OFF_STATUS, 32'h3);
      wr(OFF_MASK, 32'h1);
      go(int'(rows[i].w), rows[i].idle, rows[i].en);
      rd(OFF_STATUS);
      chk("status", 32'h1, rv);
      chk("irq", 32'h1, {31'h0, iv});
      rd(OFF_CAPTURE);
      ok = (rv + 32'h1 >= 32'(rows[i].e)) && (rv <= 32'(rows[i].e) + 32'h1);
      chk("capture", 32'h1, {31'h0, ok});
      rd(OFF_OVFCAP);
      chk("overflows", 32'h0, rv);
    end
    // Gate closed at the start edge
    wr(OFF_CONFIG, 32'h0804);
    wr(OFF_STATUS, 32'h3);
    go(20, 1'b0, 1'b0);
    rd(OFF_STATUS);
    chk("gated", 32'h0, rv);
    // One-shot, then software re-enable
    wr(OFF_CONFIG, 32'h0006);
    rd(OFF_INFO);
    chk("auto start", 32'h1, rv);
    go(20, 1'b0, 1'b0);
    wr(OFF_MASK, 32'h0);
    rd(OFF_INFO);
    chk("one-shot info", 32'h0, rv);
    chk("masked irq", 32'h0, {31'h0, iv});
    wr(OFF_STATUS, 32'h3);
    go(20, 1'b0, 1'b0);
    rd(OFF_STATUS);
    chk("one-shot rerun", 32'h0, rv);
    rd(OFF_COUNT);
    chk("count", 32'h0, rv);
    wr(OFF_COMMAND, 32'h1);
    rd(OFF_INFO);
    chk("enable", 32'h1, rv);
    go(20, 1'b0, 1'b0);
    rd(OFF_STATUS);
    chk("re-enabled", 32'h1, rv);
    // Auto start off, disable, refused reads
    wr(OFF_CONFIG, 32'h0000);
    rd(OFF_CONFIG);
    chk("config", 32'h0, rv);
    wr(OFF_STATUS, 32'h3);
    go(20, 1'b0, 1'b0);
    rd(OFF_STATUS);
    chk("no auto start", 32'h0, rv);
    wr(OFF_COMMAND, 32'h2);
    rd(OFF_INFO);
    chk("disabled", 32'h0, rv);
    rd(8'h20);
    chk("unmapped", 32'h0, rv);
    rd(OFF_COMMAND);
    chk("command", 32'h0, rv);
    // Reset in mid-run brings back the defaults
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFF_CONFIG);
    chk("config after reset", {17'h0, CFG_RESET}, rv);
    rd(OFF_INFO);
    chk("info after reset", 32'h1, rv);
    tally_and_finish();
  end
endmodule
`default_nettype wire
